// *** hw/irq_ctrl.sv ***
// Purpose: prioritized interrupt controller with APB register access
// Assumes: CPU core signals instruction boundary and return events
// Notes: source order is vector order; index 0 is port 1 bit 0
// What this block does
// - Each source event latches its readable factor flag to one
// - Writing one clears a factor flag; writing zero does nothing
// - Reset clears all factor flags
// - Each flag has a readable writable enable; one passes request
// - Reset clears all enables, leaving only NMI possible
// - Two-bit priority field per system gives levels 0 to 3, 0 never requests
// - Equal-level systems resolve by fixed default vector ranking
// - Reset sets all priority fields to zero
// - Sources within one system follow a fixed internal ranking
// - Mask flags gate acceptance: only levels above mask pass
// - Watchdog NMI is level 4, accepted whatever the mask
// - Acceptance loads mask with accepted level; NMI loads 11
// - Return from handler restores mask held before acceptance; only one saved mask is kept, so a nested take overwrites it
// - Request stays while flag set, so uncleared flag re-interrupts
// - Exception entry starts only after current instruction completes
// - Entry pushes PC and flags, plus code bank in maximum mode
// - Branch target is a 2-byte vector fetched, no bank part
// - Fixed vector addresses per source, 0x32 reserved; here tick sources 14..18 all share vector 0x28
// - Enable bit sits at same position as flag, four register indices below
// - Port 1 sources share one priority field in bits 7 and 6
// - Accept only when flag set, enabled and level above mask
// - Requests sampled at first opcode fetch of every instruction
//
// The APB slave port was decided locally.
module irq_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event sources, one-cycle pulses in vector order
   input wire logic [18:0] srcEvent,
   input wire logic nmiEvent,
   // CPU core side
   input wire logic opcodeFetch,
   input wire logic maxMode,
   input wire logic returnFromException,
   output logic irqTake,
   output logic [7:0] vectorAddr,
   output logic pushBank,
   output logic [1:0] cpuMask
);
   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   logic [7:0] prioA_reg;
   logic [7:0] prioB_reg;
   logic [18:0] enable_reg;
   logic [18:0] flag_reg;
   logic nmiPend_reg;
   logic [1:0] mask_reg;
   logic [1:0] savedMask_reg;
   irq_ctrl_pkg::state_t state_reg;
   irq_ctrl_pkg::state_t state_next;
   logic irqTake_reg;
   logic [7:0] vector_reg;
   logic pushBank_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   // ---------------------------------------------
   // APB decode
   // ---------------------------------------------
   wire logic [15:0] idx = paddr[17:2];
   wire logic access = psel && penable && !pready_reg;
   wire logic wrStrobe = access && pwrite;
   wire logic hitPrioA = idx == irq_ctrl_pkg::IDX_PRIO_A;
   wire logic hitPrioB = idx == irq_ctrl_pkg::IDX_PRIO_B;
   wire logic hitPortEn = idx == irq_ctrl_pkg::IDX_PORT_EN;
   wire logic hitTsEn = idx == irq_ctrl_pkg::IDX_TS_EN;
   wire logic hitCdEn = idx == irq_ctrl_pkg::IDX_CD_EN;
   wire logic hitPortFlg = idx == irq_ctrl_pkg::IDX_PORT_FLG;
   wire logic hitTsFlg = idx == irq_ctrl_pkg::IDX_TS_FLG;
   wire logic hitCdFlg = idx == irq_ctrl_pkg::IDX_CD_FLG;
   wire logic hitMask = idx == irq_ctrl_pkg::IDX_MASK;
   wire logic mapped = hitPrioA || hitPrioB || hitPortEn || hitTsEn || hitCdEn
      || hitPortFlg || hitTsFlg || hitCdFlg || hitMask;
   wire logic [7:0] wb = pwdata[7:0];

   // Byte views; source order 0..3 port1 bits, 4 port0, 5..9 timers, 10..12 serial,
   // 13 display, 14..18 tick sources (32,8,2,1 Hz, minute)
   wire logic [7:0] portEnByte = {enable_reg[3:0], enable_reg[4], 3'h0};
   wire logic [7:0] tsEnByte = {enable_reg[9:5], enable_reg[12:10]};
   wire logic [7:0] cdEnByte = {enable_reg[18:14], enable_reg[13], 2'h0};
   wire logic [7:0] portFlByte = {flag_reg[3:0], flag_reg[4], 3'h0};
   wire logic [7:0] tsFlByte = {flag_reg[9:5], flag_reg[12:10]};
   wire logic [7:0] cdFlByte = {flag_reg[18:14], flag_reg[13], 2'h0};

   // Write byte mapped back to source order
   wire logic [18:0] enWrMask = {hitCdEn ? 6'h3f : 6'h0, hitTsEn ? 8'hff : 8'h0,
      hitPortEn ? 5'h1f : 5'h0};
   wire logic [18:0] wrSrc = hitCdEn || hitCdFlg ? {wb[7:3], wb[2], 13'h0}
      : (hitTsEn || hitTsFlg ? {6'h0, wb[2:0], wb[7:3], 5'h0}
      : {14'h0, wb[3], wb[7:4]});
   wire logic [18:0] srcSelFl = {hitCdFlg ? 6'h3f : 6'h0, hitTsFlg ? 8'hff : 8'h0,
      hitPortFlg ? 5'h1f : 5'h0};
   wire logic [18:0] clearBits = wrStrobe ? (wrSrc & srcSelFl) : 19'h0;
   wire logic [18:0] enable_next = wrStrobe
      ? ((enable_reg & ~enWrMask) | (wrSrc & enWrMask)) : enable_reg;
   // Set wins over a clear in the same cycle
   wire logic [18:0] flag_next = (flag_reg & ~clearBits) | srcEvent;

   wire logic [7:0] readByte = hitPrioA ? prioA_reg : hitPrioB ? prioB_reg
      : hitPortEn ? portEnByte : hitTsEn ? tsEnByte : hitCdEn ? cdEnByte
      : hitPortFlg ? portFlByte : hitTsFlg ? tsFlByte : hitCdFlg ? cdFlByte
      : hitMask ? {6'h0, mask_reg} : 8'h0;

   // ---------------------------------------------
   // Priority resolution
   // ---------------------------------------------
   // Per-source level from its system field
   logic [1:0] lvl [18:0];
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lvl[i] = prioA_reg[7:6];
      end
      lvl[4] = prioA_reg[5:4];
      lvl[5] = prioA_reg[1:0];
      lvl[6] = prioA_reg[1:0];
      lvl[7] = prioA_reg[3:2];
      lvl[8] = prioA_reg[3:2];
      lvl[9] = prioB_reg[7:6];
      for (int i = 10; i < 13; i++) begin
         lvl[i] = prioB_reg[5:4];
      end
      lvl[13] = prioB_reg[1:0];
      for (int i = 14; i < 19; i++) begin
         lvl[i] = prioB_reg[3:2];
      end
   end

   wire logic [18:0] active = flag_reg & enable_reg;
   // Highest level wins; among equal, lowest index (vector order)
   logic [1:0] bestLvl;
   logic [4:0] bestIdx;
   always_comb begin
      bestLvl = 2'h0;
      bestIdx = 5'h0;
      for (int i = 18; i >= 0; i--) begin
         if (active[i] && lvl[i] != 2'h0 && lvl[i] >= bestLvl) begin
            bestLvl = lvl[i];
            bestIdx = 5'(i);
         end
      end
   end
   wire logic irqPending = bestLvl > mask_reg;

   // Vector per source; tick sources share one vector
   wire logic [7:0] srcVector = bestIdx < 5'd4 ? 8'(irq_ctrl_pkg::VEC_PORT1 + {bestIdx[1:0], 1'b0})
      : bestIdx == 5'd4 ? irq_ctrl_pkg::VEC_PORT0
      : bestIdx < 5'd10 ? 8'(irq_ctrl_pkg::VEC_TIMER + {bestIdx - 5'd5, 1'b0})
      : bestIdx < 5'd13 ? 8'(irq_ctrl_pkg::VEC_SERIAL + {bestIdx - 5'd10, 1'b0})
      : bestIdx == 5'd13 ? irq_ctrl_pkg::VEC_DISPLAY : irq_ctrl_pkg::VEC_TICK;

   // Sampled only at an instruction boundary
   wire logic takeNmi = opcodeFetch && nmiPend_reg;
   wire logic takeIrq = opcodeFetch && !nmiPend_reg && irqPending;
   wire logic take = (state_reg != irq_ctrl_pkg::ST_ENTRY) && (takeNmi || takeIrq);

   always_comb begin
      case (state_reg)
         irq_ctrl_pkg::ST_RUN: state_next = take ? irq_ctrl_pkg::ST_ENTRY : irq_ctrl_pkg::ST_RUN;
         irq_ctrl_pkg::ST_ENTRY: state_next = irq_ctrl_pkg::ST_HANDLER;
         irq_ctrl_pkg::ST_HANDLER: state_next = take ? irq_ctrl_pkg::ST_ENTRY
            : returnFromException ? irq_ctrl_pkg::ST_RUN : irq_ctrl_pkg::ST_HANDLER;
         default: state_next = irq_ctrl_pkg::ST_RUN;
      endcase
   end

   // Mask: accepted level on entry, saved value on return
   wire logic [1:0] mask_next = take ? (takeNmi ? irq_ctrl_pkg::MASK_NMI : bestLvl)
      : returnFromException ? savedMask_reg
      : (wrStrobe && hitMask) ? wb[1:0] : mask_reg;

   // ---------------------------------------------
   // Sequential logic
   // ---------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prioA_reg <= irq_ctrl_pkg::RESET_BYTE;
         prioB_reg <= irq_ctrl_pkg::RESET_BYTE;
         enable_reg <= 19'h0;
         flag_reg <= 19'h0;
      end else begin
         if (wrStrobe && hitPrioA) prioA_reg <= wb;
         if (wrStrobe && hitPrioB) prioB_reg <= wb;
         enable_reg <= enable_next;
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         nmiPend_reg <= 1'b0;
         mask_reg <= irq_ctrl_pkg::MASK_RESET;
         savedMask_reg <= irq_ctrl_pkg::MASK_RESET;
         state_reg <= irq_ctrl_pkg::ST_RUN;
         irqTake_reg <= 1'b0;
         vector_reg <= 8'h0;
         pushBank_reg <= 1'b0;
      end else begin
         // Kept pending through the entry cycle, where takes are blocked
         nmiPend_reg <= nmiEvent || (nmiPend_reg && !(take && takeNmi));
         mask_reg <= mask_next;
         if (take) savedMask_reg <= mask_reg;
         state_reg <= state_next;
         irqTake_reg <= take;
         if (take) vector_reg <= takeNmi ? irq_ctrl_pkg::VEC_NMI : srcVector;
         if (take) pushBank_reg <= maxMode;
      end
   end

   // Single wait state: answer one cycle into the access phase
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= access;
         pslverr_reg <= access && !mapped;
         if (access && !pwrite) prdata_reg <= {24'h0, readByte};
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irqTake = irqTake_reg;
   assign vectorAddr = vector_reg;
   assign pushBank = pushBank_reg;
   assign cpuMask = mask_reg;
endmodule

// *** include/irq_ctrl_pkg.sv ***
// Purpose: constants for the prioritized interrupt controller
// Assumes: APB, 32-bit data, one register per aligned word
// Notes: register indices are byte addresses divided by four
package irq_ctrl_pkg;
   // Register indices (byte address is four times the index)
   localparam logic [15:0] IDX_PRIO_A = 16'hff20;
   localparam logic [15:0] IDX_PRIO_B = 16'hff21;
   localparam logic [15:0] IDX_PORT_EN = 16'hff23;
   localparam logic [15:0] IDX_TS_EN = 16'hff24;
   localparam logic [15:0] IDX_CD_EN = 16'hff25;
   localparam logic [15:0] IDX_PORT_FLG = 16'hff27;
   localparam logic [15:0] IDX_TS_FLG = 16'hff28;
   localparam logic [15:0] IDX_CD_FLG = 16'hff29;
   localparam logic [15:0] IDX_MASK = 16'hff30;
   // Implemented bit masks of enable/flag registers
   localparam logic [7:0] PORT_BITS = 8'hf8;
   localparam logic [7:0] TS_BITS = 8'hff;
   localparam logic [7:0] CD_BITS = 8'hfc;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] MASK_NMI = 2'h3;
   // Number of maskable sources, in vector order
   localparam int NSRC = 19;
   // Vector addresses
   localparam logic [7:0] VEC_NMI = 8'h04;
   localparam logic [7:0] VEC_PORT1 = 8'h06;
   localparam logic [7:0] VEC_PORT0 = 8'h0e;
   localparam logic [7:0] VEC_TIMER = 8'h10;
   localparam logic [7:0] VEC_SERIAL = 8'h1a;
   localparam logic [7:0] VEC_DISPLAY = 8'h24;
   localparam logic [7:0] VEC_TICK = 8'h28;
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_ENTRY = 2'h1,
      ST_HANDLER = 2'h3
   } state_t;
endpackage

// *** sim/cpu_core_model.sv ***
// Purpose: CPU core stand-in giving boundaries and returns
// Assumes: return taken only at an instruction boundary
// Notes: slow stretches instructions to five cycles
module cpu_core_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Bench control
   input wire logic slow,
   input wire logic retReq,
   // Controller side
   output logic opcodeFetch,
   output logic returnFromException
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_reg;
   logic retPend_reg;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt_reg <= 3'h0;
         retPend_reg <= 1'b0;
         opcodeFetch <= 1'b0;
         returnFromException <= 1'b0;
      end else begin
         cnt_reg <= (cnt_reg >= (slow ? 3'h4 : 3'h1)) ? 3'h0 : cnt_reg + 3'h1;
         opcodeFetch <= (cnt_reg == 3'h0);
         returnFromException <= retPend_reg && (cnt_reg == 3'h0);
         retPend_reg <= retReq || (retPend_reg && (cnt_reg != 3'h0));
      end
   end
endmodule

// *** sim/irq_ctrl_chk.sv ***
// Purpose: port checker for the interrupt controller
// Assumes: single clock, sync active-low reset
// Notes: mask moves only on a take, a return or a register write
module irq_ctrl_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   // CPU side
   input wire logic opcodeFetch,
   input wire logic maxMode,
   input wire logic returnFromException,
   input wire logic irqTake,
   input wire logic [7:0] vectorAddr,
   input wire logic pushBank,
   input wire logic [1:0] cpuMask
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wrSeen;
   assign wrSeen = psel && penable && pwrite && !pready;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_ready_time: assert property (psel && $rose(penable) |=> pready) else $error("no ready after access");
   chk_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
   chk_err_with: assert property (pslverr |-> pready) else $error("error without ready");
   chk_take_edge: assert property (irqTake |-> $past(opcodeFetch)) else $error("take off boundary");
   chk_take_gap: assert property (irqTake |=> !irqTake) else $error("take twice in a row");
   chk_nmi_mask: assert property (irqTake && vectorAddr == irq_ctrl_pkg::VEC_NMI
      |-> cpuMask == irq_ctrl_pkg::MASK_NMI) else $error("mask after nmi wrong");
   chk_mask_rise: assert property (irqTake && vectorAddr != irq_ctrl_pkg::VEC_NMI
      |-> cpuMask > $past(cpuMask)) else $error("mask not above old level");
   chk_bank_push: assert property (irqTake |-> pushBank == $past(maxMode)) else $error("bank push wrong");
   chk_vec_legal: assert property (irqTake |-> !vectorAddr[0]
      && vectorAddr inside {[8'h04:8'h1e], 8'h24, 8'h28}) else $error("illegal vector");
   chk_mask_cause: assert property ($changed(cpuMask) |-> irqTake || $past(returnFromException)
      || $past(wrSeen)) else $error("mask moved alone");
   cover property (irqTake && vectorAddr == irq_ctrl_pkg::VEC_NMI);
   cover property (pready && pslverr);
   cover property (returnFromException);
endmodule
bind irq_ctrl irq_ctrl_chk irq_ctrl_chk_i (.mclk, .rst_b, .psel, .penable, .pwrite, .pready, .pslverr,
   .opcodeFetch, .maxMode, .returnFromException, .irqTake, .vectorAddr, .pushBank, .cpuMask);

// *** sim/prioritized_interrupt_controller_tb.sv ***
// Purpose: register and acceptance tests of the controller
// Assumes: byte address is four times the register index
// Notes: nothing printed but mismatches and the verdict
module prioritized_interrupt_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, nmiEvent, maxMode, slow, retReq;
   logic opcodeFetch, returnFromException, irqTake, pushBank, e;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [18:0] srcEvent;
   logic [7:0] vectorAddr, r;
   logic [1:0] cpuMask;
   int mismatches, compares, cyc;
   logic [15:0] idx [8] = '{irq_ctrl_pkg::IDX_PRIO_A, irq_ctrl_pkg::IDX_PRIO_B, irq_ctrl_pkg::IDX_PORT_EN,
      irq_ctrl_pkg::IDX_TS_EN, irq_ctrl_pkg::IDX_CD_EN, irq_ctrl_pkg::IDX_PORT_FLG, irq_ctrl_pkg::IDX_TS_FLG,
      irq_ctrl_pkg::IDX_CD_FLG};
   irq_ctrl irq_ctrl_i (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .srcEvent, .nmiEvent, .opcodeFetch, .maxMode, .returnFromException, .irqTake, .vectorAddr, .pushBank,
      .cpuMask);
   cpu_core_model cpu_core_model_i (.mclk, .rst_b, .slow, .retReq, .opcodeFetch, .returnFromException);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic [7:0] s, input logic [7:0] x);
      compares++;
      if (s !== x) begin
         mismatches++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, x);
      end
   endtask
   task automatic end_sim;
      if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Holds the request until pready is seen at an edge
   task automatic xfer(input logic [17:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      psel <= 1'b1;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      xfer({i, 2'b00}, 1'b1, d);
   endtask
   task automatic rd(input logic [15:0] i, input logic [7:0] x);
      xfer({i, 2'b00}, 1'b0, 8'h00);
      chk(r, x);
      chk({6'h0, |prdata[31:8], e}, 8'h00);
   endtask
   task automatic wtake(input logic [7:0] v, input logic [1:0] m);
      int n;
      n = 0;
      do begin @(negedge mclk); n++; end while (irqTake !== 1'b1 && n < 100);
      chk({7'h0, irqTake}, 8'h01);
      chk(vectorAddr, v);
      chk({6'h0, cpuMask}, {6'h0, m});
   endtask
   task automatic ret;
      @(posedge mclk) retReq <= 1'b1;
      @(posedge mclk) retReq <= 1'b0;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      {rst_b, psel, penable, pwrite, nmiEvent, maxMode, slow, retReq, paddr, pwdata, srcEvent} = '0;
      {mismatches, compares, cyc} = '0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      foreach (idx[i]) rd(idx[i], 8'h00);
      xfer(18'h00010, 1'b0, 8'h00);
      chk({r[6:0], e}, 8'h01);
      wr(irq_ctrl_pkg::IDX_PORT_EN, 8'hff);
      wr(irq_ctrl_pkg::IDX_TS_EN, 8'hff);
      wr(irq_ctrl_pkg::IDX_CD_EN, 8'hff);
      rd(irq_ctrl_pkg::IDX_PORT_EN, irq_ctrl_pkg::PORT_BITS);
      rd(irq_ctrl_pkg::IDX_CD_EN, irq_ctrl_pkg::CD_BITS);
      rd(irq_ctrl_pkg::IDX_TS_EN, irq_ctrl_pkg::TS_BITS);
      @(posedge mclk) srcEvent <= 19'h7ffff;
      @(posedge mclk) srcEvent <= 19'h00000;
      rd(irq_ctrl_pkg::IDX_PORT_FLG, irq_ctrl_pkg::PORT_BITS);
      wr(irq_ctrl_pkg::IDX_TS_FLG, 8'h00);
      rd(irq_ctrl_pkg::IDX_TS_FLG, 8'hff);
      wr(irq_ctrl_pkg::IDX_TS_FLG, 8'h10);
      rd(irq_ctrl_pkg::IDX_TS_FLG, 8'hef);
      for (int i = 5; i < 8; i++) wr(idx[i], 8'hff);
      rd(irq_ctrl_pkg::IDX_CD_FLG, 8'h00);
      wr(irq_ctrl_pkg::IDX_PRIO_A, 8'h42);
      slow <= 1'b1;
      @(posedge mclk) srcEvent <= 19'h00023;
      @(posedge mclk) srcEvent <= 19'h00000;
      wtake(irq_ctrl_pkg::VEC_TIMER, 2'h2);
      chk({7'h0, pushBank}, 8'h00);
      wr(irq_ctrl_pkg::IDX_TS_FLG, 8'h08);
      ret();
      wtake(irq_ctrl_pkg::VEC_PORT1, 2'h1);
      ret();
      wtake(irq_ctrl_pkg::VEC_PORT1, 2'h1);
      wr(irq_ctrl_pkg::IDX_PORT_FLG, 8'h10);
      ret();
      wtake(8'h08, 2'h1);
      @(posedge mclk) maxMode <= 1'b1;
      @(posedge mclk) nmiEvent <= 1'b1;
      @(posedge mclk) nmiEvent <= 1'b0;
      wtake(irq_ctrl_pkg::VEC_NMI, 2'h3);
      chk({7'h0, pushBank}, 8'h01);
      ret();
      repeat (12) @(negedge mclk);
      chk({6'h0, cpuMask}, 8'h01);
      wr(irq_ctrl_pkg::IDX_MASK, 8'h00);
      wtake(8'h08, 2'h1);
      rd(irq_ctrl_pkg::IDX_MASK, 8'h01);
      end_sim();
   end
endmodule
